// >>> hw/rse_defs.svh
// Purpose: Offsets, field positions and reset values of the signaling block
// Assumes: 8-bit register port, 8-bit data
// Notes:   Definitions only
`ifndef RSE_DEFS_SVH
`define RSE_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RSE_OFF_CFG    8'hD2
`define RSE_OFF_STAT   8'hD3
`define RSE_OFF_CTRL   8'hD4
`define RSE_OFF_DATA   8'hD5
`define RSE_OFF_FLAG0  8'hD6
`define RSE_OFF_FLAG1  8'hD7
`define RSE_OFF_FLAG2  8'hD8
`define RSE_OFF_FLAG3  8'hD9
`define RSE_OFF_IST    8'hDA
`define RSE_OFF_IMASK  8'hDB

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RSE_CFG_FREEZE   3
`define RSE_CFG_DEBOUNCE 2
`define RSE_CFG_IRQ_EN   1
`define RSE_CFG_MASK     8'h0E
`define RSE_CTRL_READ    7
`define RSE_SLOT_EN      4
`define RSE_IST_CHG      0
`define RSE_IST_DONE     1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RSE_CFG_RST    8'h00
`define RSE_CTRL_RST   8'h00
`define RSE_DATA_RST   8'h00
`define RSE_EN_RST     32'hFFFFFFFF

`endif

// >>> hw/rse_pkg.sv
// Purpose: Types and helpers of the signaling block
// Assumes: E1 timeslots 0..31, flags skip TS0 and TS16
// Notes:   No import; use rse_pkg::name
package rse_pkg;

    typedef enum logic [1:0]
    {
        acc_idle = 2'b01,
        acc_run  = 2'b10
    } rse_acc_t;

    typedef struct packed
    {
        rse_acc_t    state;
        logic [7:0]  cfg;
        logic [7:0]  ctrl;
        logic [7:0]  data;
        logic [29:0] flags;
        logic [1:0]  ist;
        logic [1:0]  imask;
        logic [7:0]  rdata;
        logic        irq;
    } rse_top_t;

    typedef struct packed
    {
        logic [31:0][3:0] abcd;
        logic [31:0][3:0] last;
        logic [31:0]      en;
        logic             chg;
        logic [4:0]       chg_slot;
    } rse_store_t;

    function automatic logic rse_slot_ok(input logic [6:0] a);
        return (a[6:5] == 2'h0) && (a[3:0] != 4'h0);
    endfunction : rse_slot_ok

    function automatic logic [4:0] rse_flag_idx(input logic [4:0] ts);
        return 5'(ts - (ts[4] ? 5'h2 : 5'h1));
    endfunction : rse_flag_idx

endpackage : rse_pkg

// >>> hw/rse_slot_store.sv
// Purpose: Per-timeslot ABCD store with enable, freeze and de-bounce
// Assumes: Codewords arrive on clk_in from the framer, one per pulse
// Notes:   Read port is combinational; the top registers it
`timescale 1ns/1ps
`include "rse_defs.svh"

module rse_slot_store
(
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       cw_valid_in,
    input  wire logic [4:0] cw_slot_in,
    input  wire logic [3:0] cw_abcd_in,
    input  wire logic       mf_sync_in,
    input  wire logic       freeze_in,
    input  wire logic       debounce_in,
    input  wire logic       acc_we_in,
    input  wire logic [4:0] acc_slot_in,
    input  wire logic       acc_en_in,
    output logic [7:0]      acc_rdata_out,
    output logic            chg_out,
    output logic [4:0]      chg_slot_out
);

    rse_pkg::rse_store_t st;
    rse_pkg::rse_store_t next_st;
    logic                take;

    always_comb
    begin
        next_st = st;
        next_st.chg = 1'b0;
        take = 1'b0;
        if (acc_we_in)
        begin
            next_st.en[acc_slot_in] = acc_en_in;
        end
        if (cw_valid_in && rse_pkg::rse_slot_ok({2'h0, cw_slot_in}))
        begin
            next_st.last[cw_slot_in] = cw_abcd_in;
            take = st.en[cw_slot_in] && mf_sync_in && !freeze_in
                && (!debounce_in || cw_abcd_in == st.last[cw_slot_in]);
            if (take && cw_abcd_in != st.abcd[cw_slot_in])
            begin
                next_st.abcd[cw_slot_in] = cw_abcd_in;
                next_st.chg = 1'b1;
                next_st.chg_slot = cw_slot_in;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st.abcd <= '0;
            st.last <= '0;
            st.en <= `RSE_EN_RST;
            st.chg <= 1'b0;
            st.chg_slot <= 5'h00;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign acc_rdata_out = {3'h0, st.en[acc_slot_in], st.abcd[acc_slot_in]};
    assign chg_out = st.chg;
    assign chg_slot_out = st.chg_slot;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_freeze_holds_abcd: assert property (freeze_in |=> $stable(st.abcd))
        else $error("ABCD changed while frozen");
    a_debounce_needs_pair: assert property (
        debounce_in && cw_valid_in && cw_abcd_in != st.last[cw_slot_in] |=> !st.chg)
        else $error("De-bounce let a single codeword through");
    a_sync_gates_update: assert property (!mf_sync_in |=> !st.chg)
        else $error("Extraction without multiframe sync");

endmodule : rse_slot_store

// >>> hw/rse_top.sv
// Purpose: Receive signaling extraction control for one E1 link
// Assumes: Framer codeword strobes and sync level run on clk_in
// Notes:   Indirect access takes one busy cycle
//
// How it works
// - Freeze holds all extracted ABCD values
// - De-bounce needs two equal consecutive codewords
// - Interrupt when any flag set and enabled
// - Busy shows indirect access in progress
// - Control: bit 7 read, bits 6-0 address
// - Write: load data, then address with write
// - Read: address with read, data lands
// - Flag set when timeslot signaling changes
// - Writing one clears a flag
// - Flags 1-15 map TS1-15, 16 to TS17
// - Flags 17-30 map TS18-31, top bits reserved
// - One indirect address per signaling timeslot
// - Enable bit 4 resets one, gates extraction
`timescale 1ns/1ps
`include "rse_defs.svh"

module rse_top
(
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    input  wire logic       cw_valid_in,
    input  wire logic [4:0] cw_slot_in,
    input  wire logic [3:0] cw_abcd_in,
    input  wire logic       mf_sync_in,
    output logic [7:0]      rdata_out,
    output logic            irq_out
);

    rse_pkg::rse_top_t st;
    rse_pkg::rse_top_t next_st;

    logic        store_we;
    logic [7:0]  store_rdata;
    logic        chg;
    logic [4:0]  chg_slot;
    logic [29:0] clr;
    logic [1:0]  ist_clr;
    logic        running;
    logic        idle;
    logic        acc_ok;

    // ------------------------------------------------------------------------
    // Timeslot store
    // ------------------------------------------------------------------------
    rse_slot_store u_store
    (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .cw_valid_in   (cw_valid_in),
        .cw_slot_in    (cw_slot_in),
        .cw_abcd_in    (cw_abcd_in),
        .mf_sync_in    (mf_sync_in),
        .freeze_in     (st.cfg[`RSE_CFG_FREEZE]),
        .debounce_in   (st.cfg[`RSE_CFG_DEBOUNCE]),
        .acc_we_in     (store_we),
        .acc_slot_in   (st.ctrl[4:0]),
        .acc_en_in     (st.data[`RSE_SLOT_EN]),
        .acc_rdata_out (store_rdata),
        .chg_out       (chg),
        .chg_slot_out  (chg_slot)
    );

    assign running = (st.state == rse_pkg::acc_run);
    assign idle = (st.state == rse_pkg::acc_idle);
    // Out-of-range addresses write nothing and read zero rather than alias a timeslot
    assign acc_ok = rse_pkg::rse_slot_ok(st.ctrl[6:0]);

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        store_we = 1'b0;
        clr = 30'h0;
        ist_clr = 2'h0;
        next_st.rdata = 8'h00;

        // Register writes
        if (wr_in)
        begin
            if (addr_in == `RSE_OFF_CFG)
            begin
                next_st.cfg = wdata_in & `RSE_CFG_MASK;
            end
            else if (addr_in == `RSE_OFF_CTRL)
            begin
                // Ignored while busy so a running access is never retargeted
                if (idle)
                begin
                    next_st.ctrl = wdata_in;
                    next_st.state = rse_pkg::acc_run;
                end
            end
            else if (addr_in == `RSE_OFF_DATA)
            begin
                if (idle)
                begin
                    next_st.data = wdata_in;
                end
            end
            else if (addr_in == `RSE_OFF_FLAG0)
            begin
                clr[7:0] = wdata_in;
            end
            else if (addr_in == `RSE_OFF_FLAG1)
            begin
                clr[15:8] = wdata_in;
            end
            else if (addr_in == `RSE_OFF_FLAG2)
            begin
                clr[23:16] = wdata_in;
            end
            else if (addr_in == `RSE_OFF_FLAG3)
            begin
                clr[29:24] = wdata_in[5:0];
            end
            else if (addr_in == `RSE_OFF_IMASK)
            begin
                next_st.imask = wdata_in[1:0];
            end
        end

        // Register reads; data stands one cycle only
        if (rd_in)
        begin
            if (addr_in == `RSE_OFF_CFG)
            begin
                next_st.rdata = st.cfg;
            end
            else if (addr_in == `RSE_OFF_STAT)
            begin
                next_st.rdata = {7'h00, running};
            end
            else if (addr_in == `RSE_OFF_CTRL)
            begin
                next_st.rdata = st.ctrl;
            end
            else if (addr_in == `RSE_OFF_DATA)
            begin
                next_st.rdata = st.data;
            end
            else if (addr_in == `RSE_OFF_FLAG0)
            begin
                next_st.rdata = st.flags[7:0];
            end
            else if (addr_in == `RSE_OFF_FLAG1)
            begin
                next_st.rdata = st.flags[15:8];
            end
            else if (addr_in == `RSE_OFF_FLAG2)
            begin
                next_st.rdata = st.flags[23:16];
            end
            else if (addr_in == `RSE_OFF_FLAG3)
            begin
                next_st.rdata = {2'h0, st.flags[29:24]};
            end
            else if (addr_in == `RSE_OFF_IST)
            begin
                next_st.rdata = {6'h00, st.ist};
                ist_clr = 2'h3;
            end
            else if (addr_in == `RSE_OFF_IMASK)
            begin
                next_st.rdata = {6'h00, st.imask};
            end
            else
            begin
                next_st.rdata = 8'h00;
            end
        end

        // Clears first, so a same-cycle event wins
        next_st.flags = st.flags & ~clr;
        next_st.ist = st.ist & ~ist_clr;

        // Indirect access engine
        case (st.state)
            rse_pkg::acc_idle:
            begin
                next_st.state = next_st.state;
            end
            rse_pkg::acc_run:
            begin
                if (st.ctrl[`RSE_CTRL_READ])
                begin
                    next_st.data = acc_ok ? store_rdata : 8'h00;
                end
                else
                begin
                    store_we = acc_ok;
                end
                next_st.ist[`RSE_IST_DONE] = 1'b1;
                next_st.state = rse_pkg::acc_idle;
            end
            default:
            begin
                next_st.state = rse_pkg::acc_idle;
            end
        endcase

        // Change of signaling
        if (chg)
        begin
            next_st.flags[rse_pkg::rse_flag_idx(chg_slot)] = 1'b1;
            next_st.ist[`RSE_IST_CHG] = 1'b1;
        end

        next_st.irq = (next_st.cfg[`RSE_CFG_IRQ_EN] && (|next_st.flags))
            || (|(next_st.ist & next_st.imask));
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st.state <= rse_pkg::acc_idle;
            st.cfg <= `RSE_CFG_RST;
            st.ctrl <= `RSE_CTRL_RST;
            st.data <= `RSE_DATA_RST;
            st.flags <= 30'h0;
            st.ist <= 2'h0;
            st.imask <= 2'h0;
            st.rdata <= 8'h00;
            st.irq <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rdata_out = st.rdata;
    assign irq_out = st.irq;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    logic       wr_flag0_one;
    logic       rd_flag3;
    assign wr_flag0_one = wr_in && addr_in == `RSE_OFF_FLAG0 && wdata_in[0];
    assign rd_flag3 = rd_in && addr_in == `RSE_OFF_FLAG3;

    a_irq_on_flag: assert property (
        st.cfg[`RSE_CFG_IRQ_EN] && (|st.flags) |-> irq_out)
        else $error("Flag set and enabled but no interrupt");
    a_irq_quiet: assert property (
        !st.cfg[`RSE_CFG_IRQ_EN] && st.ist == 2'h0 |-> !irq_out)
        else $error("Interrupt without cause");
    a_busy_starts: assert property (
        wr_in && addr_in == `RSE_OFF_CTRL && idle |=> running ##1 !running)
        else $error("Busy did not run one cycle");
    a_ctrl_layout: assert property (
        wr_in && addr_in == `RSE_OFF_CTRL && idle |=> st.ctrl == $past(wdata_in))
        else $error("Control register not loaded");
    a_write_to_store: assert property (
        running && !st.ctrl[`RSE_CTRL_READ] && acc_ok |-> store_we)
        else $error("Indirect write not issued");
    a_read_lands: assert property (
        running && st.ctrl[`RSE_CTRL_READ] && acc_ok |=> st.data == $past(store_rdata))
        else $error("Indirect read data missing");
    a_flag_on_change: assert property (
        chg |=> st.flags[rse_pkg::rse_flag_idx($past(chg_slot))])
        else $error("Change did not set its flag");
    a_flag_clears: assert property (
        wr_flag0_one && !(chg && chg_slot == 5'h01) |=> !st.flags[0])
        else $error("Write one did not clear flag");
    a_reserved_zero: assert property (rd_flag3 |=> rdata_out[7:6] == 2'h0)
        else $error("Reserved bits read nonzero");
    a_read_one_cycle: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("Read data stood too long");

    // ------------------------------------------------------------------------
    // Indirect access checks
    // ------------------------------------------------------------------------
    // A refused write must leave the register as it was, not half-applied
    a_stat_shows_busy: assert property (
        rd_in && addr_in == `RSE_OFF_STAT |=> rdata_out == {7'h00, $past(running)})
        else $error("Status read did not show busy");
    a_busy_keeps_ctrl: assert property (
        wr_in && addr_in == `RSE_OFF_CTRL && running |=> st.ctrl == $past(st.ctrl))
        else $error("Control retargeted while busy");
    a_busy_keeps_data: assert property (
        wr_in && addr_in == `RSE_OFF_DATA && running && !st.ctrl[`RSE_CTRL_READ]
        |=> st.data == $past(st.data))
        else $error("Data overwritten while busy");
    a_done_reported: assert property (running |=> st.ist[`RSE_IST_DONE])
        else $error("Finished access not reported");
    a_bad_slot_zero: assert property (
        running && st.ctrl[`RSE_CTRL_READ] && !acc_ok |=> st.data == 8'h00)
        else $error("Unused indirect address returned data");

    // ------------------------------------------------------------------------
    // Configuration, flag and interrupt checks
    // ------------------------------------------------------------------------
    a_cfg_write_masked: assert property (
        wr_in && addr_in == `RSE_OFF_CFG |=> st.cfg == ($past(wdata_in) & 8'h0E))
        else $error("Reserved configuration bits stored");
    a_zero_write_keeps: assert property (
        wr_in && addr_in == `RSE_OFF_FLAG0 && !wdata_in[0] && st.flags[0] |=> st.flags[0])
        else $error("Writing zero cleared a flag");
    a_flag_skips_ts16: assert property (chg && chg_slot == 5'h11 |=> st.flags[15])
        else $error("Timeslot 17 not on flag 16");
    a_flag_top_slot: assert property (chg && chg_slot == 5'h1F |=> st.flags[29])
        else $error("Timeslot 31 not on flag 30");
    // Set beats the read clear, so only quiet cycles are checked
    a_status_read_clears: assert property (
        rd_in && addr_in == `RSE_OFF_IST && !chg && !running |=> st.ist == 2'h0)
        else $error("Status read did not clear events");

    // Event status can interrupt even with the flag enable off
    a_masked_event_irq: assert property (|(st.ist & st.imask) |-> irq_out)
        else $error("Unmasked event without interrupt");

    c_indirect_write: cover property (running && !st.ctrl[`RSE_CTRL_READ] && acc_ok);
    c_indirect_read: cover property (running && st.ctrl[`RSE_CTRL_READ] && acc_ok);
    c_change_irq: cover property (chg ##1 irq_out);
    c_set_clear_race: cover property (chg && wr_in && addr_in == `RSE_OFF_FLAG0);
    c_busy_refused: cover property (wr_in && addr_in == `RSE_OFF_DATA && running);

endmodule : rse_top

// >>> tb/test_rx_signaling_extract_ctrl.sv
// Purpose: Self-checking bench of the signaling extraction block
// Assumes: Register port with one-cycle strobes, framer strobes on clk_in
// Notes:   Reference model lives in bench arrays, seed fixed
`timescale 1ns/1ps
`include "rse_defs.svh"

module test_rx_signaling_extract_ctrl;

    logic       clk_in;
    logic       rst_in;
    logic [7:0] addr_in;
    logic [7:0] wdata_in;
    logic       wr_in;
    logic       rd_in;
    logic       cw_valid_in;
    logic [4:0] cw_slot_in;
    logic [3:0] cw_abcd_in;
    logic       mf_sync_in;
    logic [7:0] rdata_out;
    logic       irq_out;
    int         fails;
    int         checks;
    logic [3:0] abcd_m [32];
    logic [3:0] prev_m [32];
    logic       en_m   [32];
    logic [29:0] flags_m;
    logic [7:0] cfg_m;
    logic [7:0] d;

    rse_top i_rse_top
    (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .addr_in     (addr_in),
        .wdata_in    (wdata_in),
        .wr_in       (wr_in),
        .rd_in       (rd_in),
        .cw_valid_in (cw_valid_in),
        .cw_slot_in  (cw_slot_in),
        .cw_abcd_in  (cw_abcd_in),
        .mf_sync_in  (mf_sync_in),
        .rdata_out   (rdata_out),
        .irq_out     (irq_out)
    );

    always #2.5 clk_in = ~clk_in;

    // ------------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic close_out;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out

    function automatic int fidx(input int ts);
        return (ts < 16) ? ts - 1 : ts - 2;
    endfunction : fidx

    function automatic logic [7:0] flag_byte(input int i);
        logic [31:0] f;
        f = {2'b00, flags_m};
        return f[8*i +: 8];
    endfunction : flag_byte

    // ------------------------------------------------------------------------
    // Bus and framer drivers
    // ------------------------------------------------------------------------
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] v);
        addr_in  <= a;
        wdata_in <= v;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in    <= 1'b0;
        @(posedge clk_in);
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, output logic [7:0] v);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        @(negedge clk_in);
        v = rdata_out;
        @(posedge clk_in);
    endtask : bus_rd

    // Software side never starts while busy reads one
    task automatic wait_idle;
        logic [7:0] s;
        int         n;
        n = 0;
        bus_rd(`RSE_OFF_STAT, s);
        while (s[0] !== 1'b0 && n < 8)
        begin
            bus_rd(`RSE_OFF_STAT, s);
            n++;
        end
        chk(s & 8'h01, 8'h00);
    endtask : wait_idle

    task automatic ind_rd(input logic [6:0] a, output logic [7:0] v);
        bus_wr(`RSE_OFF_CTRL, {1'b1, a});
        wait_idle();
        bus_rd(`RSE_OFF_DATA, v);
    endtask : ind_rd

    task automatic ind_wr(input int ts, input logic [7:0] v);
        bus_wr(`RSE_OFF_DATA, v);
        bus_wr(`RSE_OFF_CTRL, {1'b0, 7'(ts)});
        wait_idle();
        en_m[ts] = v[4];
    endtask : ind_wr

    task automatic set_cfg(input logic [7:0] v);
        bus_wr(`RSE_OFF_CFG, v);
        cfg_m = v & 8'h0E;
    endtask : set_cfg

    task automatic cw(input int s, input logic [3:0] a, input logic y);
        logic upd;
        cw_slot_in  <= 5'(s);
        cw_abcd_in  <= a;
        mf_sync_in  <= y;
        cw_valid_in <= 1'b1;
        @(posedge clk_in);
        cw_valid_in <= 1'b0;
        @(posedge clk_in);
        if (s != 0 && s != 16)
        begin
            upd = en_m[s] && y && !cfg_m[3] && (!cfg_m[2] || a == prev_m[s]);
            if (upd && a != abcd_m[s])
                flags_m[fidx(s)] = 1'b1;
            if (upd)
                abcd_m[s] = a;
            prev_m[s] = a;
        end
    endtask : cw

    task automatic check_all;
        int i;
        for (i = 0; i < 4; i++)
        begin
            bus_rd(8'(`RSE_OFF_FLAG0 + i), d);
            chk(d, flag_byte(i));
        end
        @(negedge clk_in);
        chk({7'h00, irq_out}, {7'h00, cfg_m[1] && (flags_m != 30'h0)});
        @(posedge clk_in);
        for (i = 1; i < 32; i++)
        begin
            if (i != 16)
            begin
                ind_rd(7'(i), d);
                chk(d, {3'b000, en_m[i], abcd_m[i]});
            end
        end
    endtask : check_all

    // ------------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------------
    initial
    begin
        #200us;
        fails++;
        close_out();
    end

    initial
    begin
        clk_in = 0; rst_in = 1; addr_in = 0; wdata_in = 0; wr_in = 0; rd_in = 0;
        cw_valid_in = 0; cw_slot_in = 0; cw_abcd_in = 0; mf_sync_in = 0;
        fails = 0; checks = 0; flags_m = 0; cfg_m = 0;
        for (int i = 0; i < 32; i++)
        begin
            abcd_m[i] = 4'h0; prev_m[i] = 4'h0; en_m[i] = 1'b1;
        end
        void'($urandom(79));
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        bus_rd(`RSE_OFF_CTRL, d);
        chk(d, 8'h00);
        bus_rd(`RSE_OFF_DATA, d);
        chk(d, 8'h00);
        bus_rd(8'hC0, d);
        chk(d, 8'h00);
        check_all();
        set_cfg(8'hFF);
        bus_rd(`RSE_OFF_CFG, d);
        chk(d, 8'h0E);
        // Every signaling slot changes once, corner slots included
        set_cfg(8'h02);
        for (int t = 1; t < 32; t++)
            cw(t, 4'h9, 1'b1);
        check_all();
        bus_wr(`RSE_OFF_FLAG0, 8'h55);
        flags_m[7:0] = flags_m[7:0] & 8'hAA;
        bus_wr(`RSE_OFF_FLAG1, 8'h00);
        check_all();
        for (int i = 0; i < 4; i++)
            bus_wr(8'(`RSE_OFF_FLAG0 + i), 8'hFF);
        flags_m = 0;
        check_all();
        // Freeze, de-bounce, lost sync, disabled slot
        set_cfg(8'h08);
        cw(5, 4'h3, 1'b1);
        set_cfg(8'h04);
        cw(7, 4'h6, 1'b1);
        check_all();
        cw(7, 4'h6, 1'b1);
        cw(9, 4'hC, 1'b0);
        set_cfg(8'h00);
        ind_wr(31, 8'hEF);
        cw(31, 4'h1, 1'b1);
        check_all();
        ind_wr(31, 8'h10);
        // Busy in the cycle after the control write
        addr_in <= `RSE_OFF_CTRL; wdata_in <= 8'h85; wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0; rd_in <= 1'b1; addr_in <= `RSE_OFF_STAT;
        @(posedge clk_in);
        rd_in <= 1'b0;
        @(negedge clk_in);
        chk(rdata_out & 8'h01, 8'h01);
        @(posedge clk_in);
        // Data write during busy is dropped
        addr_in <= `RSE_OFF_CTRL; wdata_in <= 8'h83; wr_in <= 1'b1;
        @(posedge clk_in);
        addr_in <= `RSE_OFF_DATA; wdata_in <= 8'hAA;
        @(posedge clk_in);
        wr_in <= 1'b0;
        @(posedge clk_in);
        bus_rd(`RSE_OFF_DATA, d);
        chk(d, {3'b000, en_m[3], abcd_m[3]});
        bus_rd(`RSE_OFF_CTRL, d);
        chk(d, 8'h83);
        ind_rd(7'h10, d);
        chk(d, 8'h00);
        ind_rd(7'h20, d);
        chk(d, 8'h00);
        // Random traffic with config and enable changes
        for (int k = 0; k < 200; k++)
        begin
            if ($urandom % 16 == 0)
                set_cfg(8'($urandom % 8) << 1);
            if ($urandom % 32 == 0)
                ind_wr(1 + $urandom % 15, 8'($urandom));
            cw($urandom % 32, 4'($urandom), ($urandom % 8) != 0);
            if (k % 40 == 39)
                check_all();
        end
        // Masked event interrupt, cleared by status read
        set_cfg(8'h00);
        ind_wr(4, 8'h10);
        for (int i = 0; i < 4; i++)
            bus_wr(8'(`RSE_OFF_FLAG0 + i), 8'hFF);
        flags_m = 0;
        bus_rd(`RSE_OFF_IST, d);
        bus_wr(`RSE_OFF_IMASK, 8'h01);
        cw(4, ~abcd_m[4], 1'b1);
        @(negedge clk_in);
        chk({7'h00, irq_out}, 8'h01);
        @(posedge clk_in);
        bus_rd(`RSE_OFF_IST, d);
        chk(d, 8'h01);
        @(negedge clk_in);
        chk({7'h00, irq_out}, 8'h00);
        @(posedge clk_in);
        // Finished indirect access as a masked event
        bus_wr(`RSE_OFF_IMASK, 8'h02);
        ind_rd(7'h01, d);
        @(negedge clk_in);
        chk({7'h00, irq_out}, 8'h01);
        @(posedge clk_in);
        bus_rd(`RSE_OFF_IST, d);
        chk(d, 8'h02);
        close_out();
    end

endmodule : test_rx_signaling_extract_ctrl
